//--- logic/dcr_chan.sv
// Per-channel arm, manual request, done flag and trigger logic
`timescale 1ns/10ps
`include "dcr_map.svh"

module dcr_chan
(
	// Clock and reset
	input  wire logic                            ref_clk,
	input  wire logic                            resetn,
	// Register write strobes and data bits for this channel
	input  wire logic                            arm_wr,
	input  wire logic                            abort_wr,
	input  wire logic                            req_wr,
	input  wire logic                            flag_wr,
	input  wire logic                            arm_wbit,
	input  wire logic                            req_wbit,
	input  wire logic                            flag_wbit,
	// Transfer engine side
	input  wire logic                            grant,
	input  wire logic                            count_done,
	input  wire logic                            repeat_mode,
	input  wire logic                            hw_trigger_select,
	input  wire logic [`DCR_TRIGGER_SELECT_SEL_WIDTH-1:0]  trigger_select_select,
	input  wire logic                            done_interrupt_enable,
	// Channel state
	output logic                                 channel_arm_bit,
	output logic                                 manual_trigger_request,
	output logic                                 channel_done_flag,
	output logic                                 trigger_select_event,
	output logic                                 irq_hit
);

	// ----------------------------------------------------------------
	// Next-value decode
	// ----------------------------------------------------------------
	wire logic abort_sel    = arm_wr && abort_wr && arm_wbit;   // Abort aimed here
	wire logic normal_arm   = arm_wr && !abort_wr;              // Plain arm write
	wire logic auto_disarm  = count_done && !repeat_mode;       // One-shot finished
	wire logic req_set      = req_wr && req_wbit;               // Only a one sets
	wire logic flag_clr     = flag_wr && !flag_wbit;            // Only a zero clears
	wire logic hw_enabled   = (trigger_select_select != `DCR_TRIGGER_SELECT_SEL_NONE); // Hardware trigger on
	wire logic next_arm;
	wire logic next_req;
	wire logic next_flag;
	wire logic next_trigger_select;

	// Abort first, then software write, then automatic disarm
	assign next_arm  = abort_sel   ? 1'b0 :
	                   normal_arm  ? arm_wbit :
	                   auto_disarm ? 1'b0 :
	                   channel_arm_bit;
	// Set wins over grant clear; abort drops a pending request
	assign next_req  = req_set ? 1'b1 :
	                   (grant || abort_sel) ? 1'b0 :
	                   manual_trigger_request;
	// Completion wins over a software clear
	assign next_flag = count_done ? 1'b1 :
	                   flag_clr ? 1'b0 :
	                   channel_done_flag;
	// One trigger per fresh manual request or selected hardware event
	assign next_trigger_select = channel_arm_bit &&
	                   ((req_set && !manual_trigger_request) ||
	                    (hw_enabled && hw_trigger_select));

	// ----------------------------------------------------------------
	// State flops
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			channel_arm_bit        <= 1'b0;
			manual_trigger_request <= 1'b0;
			channel_done_flag      <= 1'b0;
			trigger_select_event             <= 1'b0;
			irq_hit                <= 1'b0;
		end
		else
		begin
			channel_arm_bit        <= next_arm;
			manual_trigger_request <= next_req;
			channel_done_flag      <= next_flag;
			trigger_select_event             <= next_trigger_select;
			irq_hit                <= count_done && done_interrupt_enable;
		end
	end

endmodule : dcr_chan

//--- logic/dcr_map.svh
// Register map, field positions and reset values of the DMA channel control registers
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define DCR_ADDR_DONE_FLAGS    8'hd1
`define DCR_ADDR_SHARED_LOW    8'hd2
`define DCR_ADDR_SHARED_HIGH   8'hd3
`define DCR_ADDR_FIRST_LOW     8'hd4
`define DCR_ADDR_FIRST_HIGH    8'hd5
`define DCR_ADDR_ARM_CTRL      8'hd6
`define DCR_ADDR_MANUAL_TRIGGER_SELECT   8'hd7

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define DCR_ABORT_BIT          7
`define DCR_CHAN_COUNT         5
`define DCR_TRIGGER_SELECT_SEL_WIDTH     5
`define DCR_TRIGGER_SELECT_SEL_NONE      5'h00
`define DCR_PTR_RESET          8'h00
`define DCR_UNMAPPED_READ      8'h00

`endif

//--- logic/dcr_pkg.sv
// Shared types of the DMA channel control registers
package dcr_pkg;
	// One register byte
	typedef logic [7:0]  dcr_byte_t;
	// One descriptor pointer
	typedef logic [15:0] dcr_ptr_t;
endpackage : dcr_pkg

//--- logic/dcr_regs.sv
// Special function registers and channel control of the DMA controller
`timescale 1ns/10ps
`include "dcr_map.svh"

module dcr_regs
#(
	parameter int NUM_CH = `DCR_CHAN_COUNT  // Channel count, register layout fixes it
)
(
	// Clock and reset
	input  wire logic                              ref_clk,
	input  wire logic                              resetn,
	// Processor register port
	input  wire logic [7:0]                        sfr_addr,
	input  wire logic                              sfr_wr,
	input  wire logic                              sfr_rd,
	input  wire logic [7:0]                        sfr_wdata,
	output dcr_pkg::dcr_byte_t                     sfr_rdata,
	// Transfer engine inputs, one bit per channel, trigger selects five bits per channel
	input  wire logic [NUM_CH-1:0]                 chan_grant,
	input  wire logic [NUM_CH-1:0]                 chan_count_done,
	input  wire logic [NUM_CH-1:0]                 chan_repeat,
	input  wire logic [NUM_CH-1:0]                 chan_hw_trigger_select,
	input  wire logic [NUM_CH-1:0]                 done_interrupt_enable,
	input  wire logic [NUM_CH*`DCR_TRIGGER_SELECT_SEL_WIDTH-1:0] trigger_select,
	// Channel state toward the transfer engine
	output logic [NUM_CH-1:0]                      channel_arm_bit,
	output logic [NUM_CH-1:0]                      manual_trigger_request,
	output logic [NUM_CH-1:0]                      channel_done_flag,
	output logic [NUM_CH-1:0]                      chan_trigger_select_event,
	output logic                                   abort_pulse,
	output logic                                   done_irq,
	// Descriptor pointers
	output dcr_pkg::dcr_ptr_t                      first_channel_descriptor_pointer,
	output dcr_pkg::dcr_ptr_t                      shared_descriptor_pointer
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	// The register bytes hold exactly five channel bits below the abort bit
	if (NUM_CH != `DCR_CHAN_COUNT)
	begin : g_bad_num_ch
		$error("NUM_CH must equal the register channel count");
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire logic sel_flags  = (sfr_addr == `DCR_ADDR_DONE_FLAGS);  // Done flags
	wire logic sel_sh_lo  = (sfr_addr == `DCR_ADDR_SHARED_LOW);  // Shared pointer low
	wire logic sel_sh_hi  = (sfr_addr == `DCR_ADDR_SHARED_HIGH); // Shared pointer high
	wire logic sel_f_lo   = (sfr_addr == `DCR_ADDR_FIRST_LOW);   // Channel 0 pointer low
	wire logic sel_f_hi   = (sfr_addr == `DCR_ADDR_FIRST_HIGH);  // Channel 0 pointer high
	wire logic sel_arm    = (sfr_addr == `DCR_ADDR_ARM_CTRL);    // Arm control
	wire logic sel_req    = (sfr_addr == `DCR_ADDR_MANUAL_TRIGGER_SELECT); // Manual trigger
	wire logic wr_flags   = sfr_wr && sel_flags;
	wire logic wr_arm     = sfr_wr && sel_arm;
	wire logic wr_req     = sfr_wr && sel_req;
	wire logic wr_abort   = wr_arm && sfr_wdata[`DCR_ABORT_BIT];
	wire logic [NUM_CH-1:0] irq_hits;                            // Per-channel masked done

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	wire dcr_pkg::dcr_byte_t pad_arm;
	wire dcr_pkg::dcr_byte_t pad_req;
	wire dcr_pkg::dcr_byte_t pad_flags;
	wire dcr_pkg::dcr_byte_t next_rdata;

	// Abort and unused bits always read zero
	assign pad_arm   = {{(8-NUM_CH){1'b0}}, channel_arm_bit};
	assign pad_req   = {{(8-NUM_CH){1'b0}}, manual_trigger_request};
	assign pad_flags = {{(8-NUM_CH){1'b0}}, channel_done_flag};
	assign next_rdata =
		sel_flags ? pad_flags :
		sel_sh_lo ? shared_descriptor_pointer[7:0] :
		sel_sh_hi ? shared_descriptor_pointer[15:8] :
		sel_f_lo  ? first_channel_descriptor_pointer[7:0] :
		sel_f_hi  ? first_channel_descriptor_pointer[15:8] :
		sel_arm   ? pad_arm :
		sel_req   ? pad_req :
		`DCR_UNMAPPED_READ;

	// Read data registered on the read strobe, held otherwise
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			sfr_rdata <= 8'h00;
		else if (sfr_rd)
			sfr_rdata <= next_rdata;
	end

	// ----------------------------------------------------------------
	// Descriptor pointers
	// ----------------------------------------------------------------
	// Byte-wide loads, both pointers reset to zero
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			first_channel_descriptor_pointer <= {`DCR_PTR_RESET, `DCR_PTR_RESET};
			shared_descriptor_pointer        <= {`DCR_PTR_RESET, `DCR_PTR_RESET};
		end
		else if (sfr_wr)
		begin
			if (sel_f_lo)
				first_channel_descriptor_pointer[7:0]  <= sfr_wdata;
			if (sel_f_hi)
				first_channel_descriptor_pointer[15:8] <= sfr_wdata;
			if (sel_sh_lo)
				shared_descriptor_pointer[7:0]         <= sfr_wdata;
			if (sel_sh_hi)
				shared_descriptor_pointer[15:8]        <= sfr_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Abort pulse and combined interrupt request
	// ----------------------------------------------------------------
	// Abort tells the engine to stop the transfer in flight
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			abort_pulse <= 1'b0;
			done_irq    <= 1'b0;
		end
		else
		begin
			abort_pulse <= wr_abort;
			done_irq    <= |(chan_count_done & done_interrupt_enable);
		end
	end

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	for (genvar ch = 0; ch < NUM_CH; ch++)
	begin : g_chan
		dcr_chan u_chan
		(
			.ref_clk                (ref_clk),
			.resetn                 (resetn),
			.arm_wr                 (wr_arm),
			.abort_wr               (wr_abort),
			.req_wr                 (wr_req),
			.flag_wr                (wr_flags),
			.arm_wbit               (sfr_wdata[ch]),
			.req_wbit               (sfr_wdata[ch]),
			.flag_wbit              (sfr_wdata[ch]),
			.grant                  (chan_grant[ch]),
			.count_done             (chan_count_done[ch]),
			.repeat_mode            (chan_repeat[ch]),
			.hw_trigger_select                (chan_hw_trigger_select[ch]),
			.trigger_select_select            (trigger_select[ch*`DCR_TRIGGER_SELECT_SEL_WIDTH +:
			                                        `DCR_TRIGGER_SELECT_SEL_WIDTH]),
			.done_interrupt_enable  (done_interrupt_enable[ch]),
			.channel_arm_bit        (channel_arm_bit[ch]),
			.manual_trigger_request (manual_trigger_request[ch]),
			.channel_done_flag      (channel_done_flag[ch]),
			.trigger_select_event             (chan_trigger_select_event[ch]),
			.irq_hit                (irq_hits[ch])
		);
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	// Aborted channels are disarmed one cycle later
	chk_abort_disarms: assert property (wr_abort |=>
		((channel_arm_bit & $past(sfr_wdata[NUM_CH-1:0])) == '0))
		else $error("abort left a selected channel armed");
	// Arm register readback never shows abort or unused bits
	chk_abort_reads_zero: assert property ((sfr_rd && sel_arm) |=>
		(sfr_rdata[7:NUM_CH] == '0))
		else $error("arm register upper bits read nonzero");
	// No trigger leaves a channel that was not armed
	chk_arm_gates_trigger_select: assert property (
		(chan_trigger_select_event & ~$past(channel_arm_bit)) == '0)
		else $error("trigger on an unarmed channel");
	// One-shot count end disarms the channel
	chk_auto_disarm: assert property ((!wr_arm && |(chan_count_done & ~chan_repeat)) |=>
		((channel_arm_bit & $past(chan_count_done & ~chan_repeat)) == '0))
		else $error("one-shot channel still armed after count end");
	// Fresh manual request on an armed channel gives a trigger
	chk_manual_trigger_select: assert property (wr_req |=>
		((($past(sfr_wdata[NUM_CH-1:0] & channel_arm_bit & ~manual_trigger_request))
		  & ~chan_trigger_select_event) == '0))
		else $error("manual request did not trigger");
	// Grant clears a request that is not being set again
	chk_grant_clears: assert property ((|chan_grant && !wr_req) |=>
		((manual_trigger_request & $past(chan_grant)) == '0))
		else $error("request survived its grant");
	// Channel 0 pointer low byte loads the written value
	chk_first_ptr_load: assert property ((sfr_wr && sel_f_lo) |=>
		(first_channel_descriptor_pointer[7:0] == $past(sfr_wdata)))
		else $error("channel 0 pointer low byte not loaded");
	// Shared pointer high byte loads the written value
	chk_shared_ptr_load: assert property ((sfr_wr && sel_sh_hi) |=>
		(shared_descriptor_pointer[15:8] == $past(sfr_wdata)))
		else $error("shared pointer high byte not loaded");
	// Completion sets the flag even against a clearing write
	chk_done_sets: assert property (|chan_count_done |=>
		((channel_done_flag & $past(chan_count_done)) == $past(chan_count_done)))
		else $error("completion did not set its flag");
	// Writing ones to the flags changes nothing
	chk_flag_one_keeps: assert property ((wr_flags && (sfr_wdata == 8'hff) &&
		!(|chan_count_done)) |=> $stable(channel_done_flag))
		else $error("writing ones changed a done flag");
	// Writing zero clears the flag when no completion lands in the same cycle
	chk_flag_zero_clears: assert property ((wr_flags && !(|chan_count_done)) |=>
		((channel_done_flag & ~$past(sfr_wdata[NUM_CH-1:0])) == '0))
		else $error("writing zero left a done flag set");
	// Interrupt follows masked completion by one cycle
	chk_irq_masked: assert property (done_irq ==
		$past(|(chan_count_done & done_interrupt_enable)))
		else $error("interrupt does not match masked completion");
	// Channel masked hits agree with the combined request
	chk_irq_hits_agree: assert property ((|irq_hits) == done_irq)
		else $error("per-channel hits disagree with interrupt");

	// Main scenarios
	cov_abort:      cover property (wr_abort && (sfr_wdata[NUM_CH-1:0] != '0));
	cov_manual:     cover property (wr_req ##1 (|chan_trigger_select_event) ##[1:8] (|chan_grant));
	cov_done_clear: cover property ((|channel_done_flag) ##1 (wr_flags && sfr_wdata == 8'h00));
	cov_auto_off:   cover property ((|channel_arm_bit) ##1 (|(chan_count_done & ~chan_repeat)));

endmodule : dcr_regs

//--- tb/dcr_engine_model.sv
// Behavioural transfer engine that grants pending triggers and completes them
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Engine model
// ----------------------------------------------------------------
module dcr_engine_model
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	// Stall control from the bench, high holds every grant back
	input  wire logic       hold,
	// Channel state from the registers
	input  wire logic [4:0] chan_trigger_select_event,
	input  wire logic [4:0] channel_arm_bit,
	// Grant and completion pulses back to the registers
	output logic      [4:0] chan_grant,
	output logic      [4:0] chan_count_done
);
	logic [4:0] pend;  // Triggers seen but not yet granted
	logic [4:0] low;   // Lowest pending channel, one-hot

	// Lowest channel wins, a crude fixed priority
	assign low = pend & (~pend + 5'h01);

	// Grant one channel a cycle; every granted transfer ends its count next cycle
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			pend            <= 5'h00;
			chan_grant      <= 5'h00;
			chan_count_done <= 5'h00;
		end
		else
		begin
			chan_count_done <= chan_grant;
			chan_grant      <= 5'h00;
			if (!hold && (pend != 5'h00))
			begin
				// Only an armed channel may move data
				chan_grant <= low & channel_arm_bit;
				pend       <= (pend | chan_trigger_select_event) & ~low;
			end
			else
			begin
				pend <= pend | chan_trigger_select_event;
			end
		end
	end
endmodule : dcr_engine_model

//--- tb/test_dma_channel_control_regs.sv
// Self-checking bench of the DMA channel control registers
`timescale 1ns/10ps

module test_dma_channel_control_regs;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        ref_clk = 1'b0;   // System clock
	logic        resetn  = 1'b0;   // Synchronous reset
	logic [7:0]  sfr_addr = 8'h00; // Register port
	logic        sfr_wr = 1'b0;
	logic        sfr_rd = 1'b0;
	logic [7:0]  sfr_wdata = 8'h00;
	dcr_pkg::dcr_byte_t sfr_rdata;
	logic [4:0]  grant, cdone, arm, req, flag, tev;
	logic [4:0]  rep = 5'h00;      // Repeating mode per channel
	logic [4:0]  hwt = 5'h00;      // Hardware trigger pulses
	logic [4:0]  ien = 5'h1f;      // Interrupt enables
	logic [24:0] tsel = 25'h0;     // Trigger selects
	logic        hold = 1'b0;      // Engine stall
	logic        abort_pulse, done_irq;
	dcr_pkg::dcr_ptr_t p_first, p_shared;
	int          num_errors = 0;
	int          checks_done = 0;
	int          tcnt [5] = '{0, 0, 0, 0, 0}; // Trigger pulses per channel
	int          icnt = 0;         // Completion interrupts
	int          acnt = 0;         // Abort pulses
	int          i0;

	always #5 ref_clk = ~ref_clk;

	dcr_regs #(.NUM_CH(5)) dut (.ref_clk(ref_clk), .resetn(resetn), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.chan_grant(grant), .chan_count_done(cdone), .chan_repeat(rep), .chan_hw_trigger_select(hwt),
		.done_interrupt_enable(ien), .trigger_select(tsel), .channel_arm_bit(arm),
		.manual_trigger_request(req), .channel_done_flag(flag), .chan_trigger_select_event(tev),
		.abort_pulse(abort_pulse), .done_irq(done_irq),
		.first_channel_descriptor_pointer(p_first), .shared_descriptor_pointer(p_shared));

	dcr_engine_model eng (.ref_clk(ref_clk), .resetn(resetn), .hold(hold),
		.chan_trigger_select_event(tev), .channel_arm_bit(arm), .chan_grant(grant),
		.chan_count_done(cdone));

	// Count one-cycle pulses as they are sampled
	always @(posedge ref_clk)
	begin
		if (resetn)
		begin
			for (int i = 0; i < 5; i++)
				tcnt[i] += (tev[i] === 1'b1) ? 1 : 0;
			icnt += (done_irq === 1'b1) ? 1 : 0;
			acnt += (abort_pulse === 1'b1) ? 1 : 0;
		end
	end

	// ----------------------------------------------------------------
	// Tasks, all entered 1 ns after a rising edge
	// ----------------------------------------------------------------
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_cnt(input int got, input int exp);
		checks_done++;
		if (got != exp)
		begin
			num_errors++;
			$display("BAD %0t count %0d expected %0d", $time, got, exp);
		end
	endtask : chk_cnt

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : idle

	// Write strobe lasts one cycle, then one idle edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		idle(1);
		sfr_wr = 1'b0;
		idle(1);
	endtask : wr

	// Read strobe lasts one cycle; data is looked at after the next edge
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		sfr_addr = a;
		sfr_rd = 1'b1;
		idle(1);
		sfr_rd = 1'b0;
		idle(1);
		chk_reg(sfr_rdata, e);
	endtask : rd

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	// Watchdog, far beyond the 142 cycles the tests need
	initial
	begin
		#100us;
		num_errors++;
		$display("BAD %0t watchdog expired", $time);
		end_of_test;
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial
	begin
		idle(4);
		resetn = 1'b1;
		for (int a = 8'hd0; a <= 8'hd7; a++)
			rd(a[7:0], 8'h00);
		$display("reset values done");
		wr(8'hd2, 8'h12);
		wr(8'hd3, 8'h34);
		wr(8'hd4, 8'h56);
		wr(8'hd5, 8'h78);
		rd(8'hd2, 8'h12);
		rd(8'hd3, 8'h34);
		rd(8'hd4, 8'h56);
		rd(8'hd5, 8'h78);
		chk_reg(p_shared[15:8], 8'h34);
		chk_reg(p_first[7:0], 8'h56);
		chk_reg(p_shared[7:0], 8'h12);
		chk_reg(p_first[15:8], 8'h78);
		$display("pointers done");
		wr(8'hd6, 8'h04);
		wr(8'hd7, 8'h04);
		idle(8);
		chk_cnt(tcnt[2], 1);
		chk_cnt(icnt, 1);
		rd(8'hd6, 8'h00);
		rd(8'hd7, 8'h00);
		rd(8'hd1, 8'h04);
		$display("manual trigger done");
		hold = 1'b1;
		wr(8'hd6, 8'h01);
		wr(8'hd7, 8'h01);
		wr(8'hd7, 8'h00);
		rd(8'hd7, 8'h01);
		chk_reg({3'h0, req}, 8'h01);
		hold = 1'b0;
		idle(6);
		rd(8'hd7, 8'h00);
		rd(8'hd1, 8'h05);
		chk_reg({3'h0, flag}, 8'h05);
		wr(8'hd1, 8'hff);
		rd(8'hd1, 8'h05);
		wr(8'hd1, 8'hfe);
		rd(8'hd1, 8'h04);
		wr(8'hd1, 8'h00);
		rd(8'hd1, 8'h00);
		$display("request and flags done");
		rep = 5'h08;
		ien = 5'h17;
		i0 = icnt;
		wr(8'hd6, 8'h08);
		wr(8'hd7, 8'h08);
		idle(8);
		rd(8'hd6, 8'h08);
		rd(8'hd1, 8'h08);
		chk_cnt(icnt, i0);
		$display("repeat mode done");
		wr(8'hd6, 8'h0a);
		hwt = 5'h02;
		idle(1);
		hwt = 5'h00;
		idle(6);
		chk_cnt(tcnt[1], 0);
		tsel = 25'h0000020;
		hwt = 5'h02;
		idle(1);
		hwt = 5'h00;
		idle(6);
		chk_cnt(tcnt[1], 1);
		rd(8'hd6, 8'h08);
		$display("hardware trigger done");
		wr(8'hd6, 8'h1f);
		wr(8'hd6, 8'h85);
		rd(8'hd6, 8'h1a);
		chk_reg({3'h0, arm}, 8'h1a);
		chk_cnt(acnt, 1);
		wr(8'hd6, 8'h7f);
		rd(8'hd6, 8'h1f);
		wr(8'hd6, 8'h1e);
		wr(8'hd1, 8'h00);
		wr(8'hd7, 8'h01);
		idle(6);
		chk_cnt(tcnt[0], 1);
		rd(8'hd1, 8'h00);
		$display("abort and disarmed done");
		end_of_test;
	end
endmodule : test_dma_channel_control_regs
